// file: shared/asc_defines.svh
// Register offsets, field positions, reset values and keys of the ADC status/control block
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH

// Register offsets (4-bit frame address)
`define ASC_ADDR_FLAGS 4'h2
`define ASC_ADDR_CMD 4'h3
`define ASC_ADDR_INSEL 4'h4
`define ASC_ADDR_AFE 4'h5
`define ASC_ADDR_MAPCRC 4'hf
`define ASC_ADDR_RESTART_LO 4'h4
`define ASC_ADDR_RESTART_HI 4'he

// Device flags field positions
`define ASC_FL_THREE_WIRE 7
`define ASC_FL_POWER_RESET 5
`define ASC_FL_LINK_CRC 4
`define ASC_FL_MAP_CRC 3
`define ASC_FL_FAULT 2
`define ASC_FL_SAT 1
`define ASC_FL_NEW_DATA 0

// Conversion command field positions and reset key
`define ASC_CMD_START 1
`define ASC_CMD_STOP 0
`define ASC_RESET_KEY 6'h16

// Writable masks: reserved bits are dropped on write
`define ASC_INSEL_MASK 8'h03
`define ASC_AFE_MASK 8'h7b

// Reset values
`define ASC_INSEL_RST 8'h00
`define ASC_AFE_RST 8'h00

`endif

// file: shared/asc_pkg.sv
// Types shared by the ADC status/control register block
package asc_pkg;

   // One register access taken from the serial frame logic
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } asc_req_s;

   // Report of the conversion datapath
   typedef struct packed {
      logic done;
      logic sat_seen;
   } asc_conv_s;

   // Conversion control mode selected by the trigger mode field
   typedef enum logic [1:0] {
      ASC_TRIG_START_STOP = 2'h0,
      ASC_TRIG_ONE_SHOT = 2'h1,
      ASC_TRIG_SYNC = 2'h2,
      ASC_TRIG_RSVD = 2'h3
   } asc_trig_e;

   // Conversion state, Gray coded along idle-run-stopping-single
   typedef enum logic [1:0] {
      ASC_CV_IDLE = 2'h0,
      ASC_CV_RUN = 2'h1,
      ASC_CV_STOPPING = 2'h3,
      ASC_CV_SINGLE = 2'h2
   } asc_conv_e;

endpackage

// file: src/asc_regs.sv
// Status, command, input select and analog config registers of the delta-sigma ADC
`timescale 1ns/10ps
`include "asc_defines.svh"

module asc_regs (
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire asc_pkg::asc_req_s i_req,
   input wire asc_pkg::asc_conv_s i_conv,
   input wire logic i_data_read,
   input wire logic [1:0] i_trig_mode,
   input wire logic i_link_crc_en,
   input wire logic i_map_crc_en,
   input wire logic i_link_crc_err,
   input wire logic [7:0] i_map_crc_calc,
   input wire logic i_fault,
   input wire logic i_three_wire,
   output logic [7:0] o_rdata,
   output logic o_rvalid,
   output logic o_new_data_indicator_n,
   output logic o_conv_run,
   output logic o_conv_restart,
   output logic o_soft_reset,
   output logic [1:0] o_input_select_field,
   output logic [7:0] o_analog_front_config
);
   import asc_pkg::*;

   // True for the addresses whose write disturbs a running conversion
   // The window spans config, offset and gain; the map CRC at the top is left out
   function automatic logic is_restart_addr(input logic [3:0] a);
      is_restart_addr = (a >= `ASC_ADDR_RESTART_LO) && (a <= `ASC_ADDR_RESTART_HI);
   endfunction

   // True when a frame writes the given address
   function automatic logic wr_to(input asc_req_s r, input logic [3:0] a);
      wr_to = r.wr && (r.addr == a);
   endfunction

   asc_trig_e trig; // Decoded control mode
   logic wr_ok; // Write allowed past the link CRC lock
   logic start_cmd; // Start alone requested
   logic stop_cmd; // Stop alone requested
   logic key_cmd; // Reset key with start and stop clear

   // Conversion control state
   asc_conv_e conv_state;
   asc_conv_e next_conv_state;
   logic restart;
   logic next_restart;
   logic soft_rst;
   logic next_soft_rst;
   logic run; // Registered copy of "not idle" for the output pin
   logic next_run;

   // Flag state
   logic link_err;
   logic next_link_err;
   logic map_err;
   logic next_map_err;
   logic fault;
   logic next_fault;
   logic sat;
   logic next_sat;
   logic new_data;
   logic next_new_data;
   logic new_data_indicator_n;
   logic next_new_data_indicator_n;
   logic por;
   logic next_por;

   // Configuration and read state
   logic [1:0] insel;
   logic [1:0] next_insel;
   logic [7:0] afe;
   logic [7:0] next_afe;
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic rvalid;
   logic next_rvalid;

   // Command decode shared by the processes below
   always_comb begin
      trig = asc_trig_e'(i_trig_mode);
      // Frame logic hands over one address per access, so no multi-register writes
      wr_ok = i_req.wr && (!link_err || i_req.addr == `ASC_ADDR_FLAGS);
      // Start and stop decode as exclusive pairs; both high means nothing
      start_cmd = wr_ok && (i_req.addr == `ASC_ADDR_CMD) &&
                  i_req.wdata[`ASC_CMD_START] && !i_req.wdata[`ASC_CMD_STOP];
      stop_cmd = wr_ok && (i_req.addr == `ASC_ADDR_CMD) &&
                 i_req.wdata[`ASC_CMD_STOP] && !i_req.wdata[`ASC_CMD_START];
      // Key is honoured only with start and stop low, else it is a plain command
      key_cmd = wr_ok && (i_req.addr == `ASC_ADDR_CMD) &&
                (i_req.wdata[7:2] == `ASC_RESET_KEY) && (i_req.wdata[1:0] == 2'h0);
   end

   // Conversion control next state
   always_comb begin
      next_conv_state = conv_state;
      next_restart = 1'b0;
      next_soft_rst = key_cmd;
      case (conv_state)
         ASC_CV_IDLE: begin
            // Stop has nothing to act on; config writes do not start conversions
            if (start_cmd) begin
               next_restart = 1'b1;
               // one conversion only in one-shot mode
               next_conv_state = (trig == ASC_TRIG_ONE_SHOT) ? ASC_CV_SINGLE : ASC_CV_RUN;
            end
         end
         ASC_CV_RUN: begin
            // Start has priority over stop; a config write only restarts
            if (start_cmd) begin
               next_restart = 1'b1;
            end else if (stop_cmd && trig != ASC_TRIG_SYNC) begin
               next_conv_state = ASC_CV_STOPPING;
            end else if (wr_ok && is_restart_addr(i_req.addr)) begin
               next_restart = 1'b1;
            end
         end
         ASC_CV_STOPPING: begin
            // Finish the conversion in flight, then go quiet
            // A start while stopping cancels the stop and resumes running
            if (start_cmd) begin
               next_restart = 1'b1;
               next_conv_state = ASC_CV_RUN;
            end else if (i_conv.done) begin
               next_conv_state = ASC_CV_IDLE;
            end else if (wr_ok && is_restart_addr(i_req.addr)) begin
               next_restart = 1'b1;
            end
         end
         ASC_CV_SINGLE: begin
            // Stop has no meaning here: the single conversion runs to its end
            if (start_cmd) begin
               next_restart = 1'b1;
            end else if (i_conv.done) begin
               next_conv_state = ASC_CV_IDLE;
            end else if (wr_ok && is_restart_addr(i_req.addr)) begin
               next_restart = 1'b1;
            end
         end
         default: begin
            next_conv_state = ASC_CV_IDLE;
         end
      endcase
      // A keyed reset overrides everything else in the same cycle
      if (soft_rst) begin
         next_conv_state = ASC_CV_IDLE;
         next_restart = 1'b0;
      end
      // Run flag follows the next state so the pin needs no decode after the flop
      next_run = (next_conv_state != ASC_CV_IDLE);
   end

   // Conversion control registers
   // Reset drops any pending restart so no stray start follows power-up
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         conv_state <= ASC_CV_IDLE;
         restart <= 1'b0;
         soft_rst <= 1'b0;
         run <= 1'b0;
      end else begin
         conv_state <= next_conv_state;
         restart <= next_restart;
         soft_rst <= next_soft_rst;
         run <= next_run;
      end
   end

   // Flag next values; hardware sets win over W1C and read clears, the keyed reset wins over all
   always_comb begin
      // link error is W1C, a new error in the same cycle wins
      next_link_err = link_err;
      if (wr_to(i_req, `ASC_ADDR_FLAGS) && i_req.wdata[`ASC_FL_LINK_CRC]) begin
         next_link_err = 1'b0;
      end
      if (i_link_crc_err && i_link_crc_en) begin
         next_link_err = 1'b1;
      end
      // Map CRC flag: cleared by W1C or by disabling the check
      // Disabling the check wins even over a mismatch in the same cycle
      next_map_err = map_err;
      if (wr_ok && (i_req.addr == `ASC_ADDR_FLAGS) && i_req.wdata[`ASC_FL_MAP_CRC]) begin
         next_map_err = 1'b0;
      end
      if (wr_ok && (i_req.addr == `ASC_ADDR_MAPCRC) && i_map_crc_en &&
          (i_req.wdata != i_map_crc_calc)) begin
         next_map_err = 1'b1;
      end
      if (!i_map_crc_en) begin
         next_map_err = 1'b0;
      end
      // Fault is sticky; W1C does not reach it, only the keyed reset write re-samples it
      // Limitation: a fault that clears itself still reads set until a reset
      next_fault = fault | i_fault;
      // Saturation reflects only the conversion just completed
      next_sat = i_conv.done ? i_conv.sat_seen : sat;
      // New data: one-shot holds it until the next start instead of the read
      next_new_data = new_data;
      if (trig == ASC_TRIG_ONE_SHOT) begin
         if (start_cmd) begin
            next_new_data = 1'b0;
         end
      end else if (i_data_read) begin
         next_new_data = 1'b0;
      end
      // Completion wins over a read in the same cycle so no sample is lost
      if (i_conv.done) begin
         next_new_data = 1'b1;
      end
      // Power/user reset indicator, W1C
      // Any reset, power-up or keyed, leaves this set for the host to see
      next_por = por;
      if (wr_to(i_req, `ASC_ADDR_FLAGS) && i_req.wdata[`ASC_FL_POWER_RESET]) begin
         next_por = 1'b0;
      end
      // Keyed reset returns every flag to its power-up value; fault is re-sampled
      if (soft_rst) begin
         next_link_err = 1'b0;
         next_map_err = 1'b0;
         next_sat = 1'b0;
         next_new_data = 1'b0;
         next_fault = i_fault;
         next_por = 1'b1;
      end
      // Pin tracks the bit exactly, both updated on the same edge
      next_new_data_indicator_n = ~next_new_data;
   end

   // Flag registers
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         link_err <= 1'b0;
         map_err <= 1'b0;
         fault <= 1'b0;
         sat <= 1'b0;
         new_data <= 1'b0;
         // Pin idles high: no data yet, matching the cleared new-data bit
         new_data_indicator_n <= 1'b1;
         por <= 1'b1;
      end else begin
         link_err <= next_link_err;
         map_err <= next_map_err;
         fault <= next_fault;
         sat <= next_sat;
         new_data <= next_new_data;
         new_data_indicator_n <= next_new_data_indicator_n;
         por <= next_por;
      end
   end

   // Configuration writes and read answers
   always_comb begin
      next_insel = insel;
      next_afe = afe;
      if (wr_ok && i_req.addr == `ASC_ADDR_INSEL) begin
         // Upper select bits are never stored, so they cannot read back
         next_insel = i_req.wdata[1:0];
      end
      if (wr_ok && i_req.addr == `ASC_ADDR_AFE) begin
         next_afe = i_req.wdata & `ASC_AFE_MASK;
      end
      if (soft_rst) begin
         next_insel = 2'(`ASC_INSEL_RST);
         next_afe = `ASC_AFE_RST;
      end
      // Reads keep working while the link CRC lock is up
      next_rvalid = i_req.rd;
      // Read data hold between reads so a slow host can still pick them up
      next_rdata = rdata;
      if (i_req.rd) begin
         case (i_req.addr)
            `ASC_ADDR_FLAGS: begin
               next_rdata = {i_three_wire, 1'b0, por, link_err, map_err,
                             fault, sat, new_data};
            end
            `ASC_ADDR_CMD: begin
               // Key field and self-clearing stop always read back zero
               next_rdata = 8'h00;
            end
            `ASC_ADDR_INSEL: begin
               next_rdata = {6'h00, insel} & `ASC_INSEL_MASK;
            end
            `ASC_ADDR_AFE: begin
               next_rdata = afe;
            end
            default: begin
               next_rdata = 8'h00;
            end
         endcase
      end
   end

   // Configuration and read registers
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         insel <= 2'h0;
         afe <= 8'h00;
         rdata <= 8'h00;
         rvalid <= 1'b0;
      end else begin
         insel <= next_insel;
         afe <= next_afe;
         rdata <= next_rdata;
         rvalid <= next_rvalid;
      end
   end

   // All outputs straight from flops
   // Each output is a flop copy, so no decode glitches reach the pins
   always_comb begin
      o_rdata = rdata;
      o_rvalid = rvalid;
      o_new_data_indicator_n = new_data_indicator_n;
      o_conv_run = run;
      o_conv_restart = restart;
      o_soft_reset = soft_rst;
      o_input_select_field = insel;
      o_analog_front_config = afe;
   end

endmodule

// file: test/asc_regs_checker.sv
// Port assertions of the status/control register block
`timescale 1ns/10ps
module asc_regs_checker (
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire asc_pkg::asc_req_s i_req,
   input wire asc_pkg::asc_conv_s i_conv,
   input wire logic [7:0] o_rdata,
   input wire logic o_rvalid,
   input wire logic o_new_data_indicator_n,
   input wire logic o_conv_run,
   input wire logic o_conv_restart,
   input wire logic o_soft_reset,
   input wire logic [1:0] o_input_select_field,
   input wire logic [7:0] o_analog_front_config
);
   import asc_pkg::*;
   // One clock domain, so clocking and reset are shared
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);
   // Read answer comes exactly one cycle after the strobe
   property p_rv; o_rvalid == $past(i_req.rd); endproperty
   a_rv: assert property (p_rv) else $error("read answer timing");
   // Status bit 0 mirrors the ready pin inverted
   property p_nd; i_req.rd && i_req.addr == 4'h2 |=> o_rdata[0] == !$past(o_new_data_indicator_n); endproperty
   a_nd: assert property (p_nd) else $error("new data bit vs pin");
   // Command register never reads back key or stop
   property p_cmd; i_req.rd && i_req.addr == 4'h3 |=> o_rdata == 8'h00; endproperty
   a_cmd: assert property (p_cmd) else $error("command reads nonzero");
   // Input select reads its field with zero upper bits
   property p_sel;
      i_req.rd && i_req.addr == 4'h4 && !o_soft_reset |=>
         o_rdata == {6'h00, o_input_select_field};
   endproperty
   a_sel: assert property (p_sel) else $error("select readback");
   // Reserved analog config bits stay low
   property p_afe; !o_analog_front_config[7] && !o_analog_front_config[2]; endproperty
   a_afe: assert property (p_afe) else $error("reserved config bit set");
   // Config writes while idle must not start conversions
   property p_idle;
      i_req.wr && i_req.addr inside {[4'h4:4'he]} && !o_conv_run |=> !o_conv_restart;
   endproperty
   a_idle: assert property (p_idle) else $error("idle write started");
   // Conversions only end on a completed conversion or reset
   property p_stop; $fell(o_conv_run) |-> $past(i_conv.done) || $past(o_soft_reset); endproperty
   a_stop: assert property (p_stop) else $error("run ended early");
   // Keyed reset only follows the exact key write
   property p_key;
      o_soft_reset |-> $past(i_req.wr && i_req.addr == 4'h3 && i_req.wdata == 8'h58);
   endproperty
   a_key: assert property (p_key) else $error("stray soft reset");
endmodule
bind asc_regs asc_regs_checker chk (.i_mclk, .i_arst_n, .i_req, .i_conv, .o_rdata, .o_rvalid,
   .o_new_data_indicator_n, .o_conv_run, .o_conv_restart, .o_soft_reset, .o_input_select_field,
   .o_analog_front_config);

// file: test/asc_host.sv
// Host model issuing single register accesses
`timescale 1ns/10ps
module asc_host (
   input wire logic i_mclk,
   input wire logic [7:0] i_rdata,
   output asc_pkg::asc_req_s o_req
);
   import asc_pkg::*;
   initial o_req = '0;
   // Held through the taking edge; idle bus shows inverted stale data
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      #1 o_req = '{1'b1, 1'b0, a, d};
      @(posedge i_mclk);
      #1 o_req = '{1'b0, 1'b0, ~a, ~d};
   endtask
   // Data is taken one cycle after the strobe edge
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge i_mclk);
      #1 o_req = '{1'b0, 1'b1, a, 8'h00};
      @(posedge i_mclk);
      #1 o_req = '{1'b0, 1'b0, ~a, 8'hff};
      d = i_rdata;
   endtask
   // Command register is cleared before every start
   task automatic start;
      wr(4'h3, 8'h00);
      wr(4'h3, 8'h02);
   endtask
   // Key with start and stop both zero
   task automatic key;
      wr(4'h3, {6'h16, 2'h0});
   endtask
endmodule

// file: test/asc_regs_bench.sv
// Self-checking bench of the status/control register block
`timescale 1ns/10ps
module asc_regs_bench;
   import asc_pkg::*;
   logic i_mclk = 1'b0;
   logic i_arst_n = 1'b0;
   asc_req_s req;
   asc_conv_s cv = '0;
   logic dr = 1'b0, le = 1'b0, me = 1'b0, lerr = 1'b0, flt = 1'b0;
   logic [1:0] tm = 2'h0;
   logic [1:0] sel;
   logic [7:0] rdata, afe, d;
   logic run, restart, srst, rv;
   logic new_data_indicator_n;
   int num_errors = 0;
   int checked = 0;
   always #2 i_mclk = ~i_mclk;
   asc_host h (.i_mclk, .i_rdata(rdata), .o_req(req));
   asc_regs dut (.i_mclk, .i_arst_n, .i_req(req), .i_conv(cv), .i_data_read(dr),
      .i_trig_mode(tm), .i_link_crc_en(le), .i_map_crc_en(me), .i_link_crc_err(lerr),
      .i_map_crc_calc(8'h5a), .i_fault(flt), .i_three_wire(1'b1), .o_rdata(rdata),
      .o_rvalid(rv), .o_new_data_indicator_n(new_data_indicator_n), .o_conv_run(run), .o_conv_restart(restart),
      .o_soft_reset(srst), .o_input_select_field(sel), .o_analog_front_config(afe));
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic rc(input logic [3:0] a, input logic [7:0] e);
      h.rd(a, d);
      chk({7'h0, rv}, 8'h01);
      chk(d, e);
   endtask
   // One-cycle strobes: bit2 fault, bit1 data read, bit0 link error
   task automatic pls(input logic [2:0] k);
      @(posedge i_mclk);
      #1 {flt, dr, lerr} = k;
      @(posedge i_mclk);
      #1 {flt, dr, lerr} = 3'h0;
   endtask
   task automatic done_p(input logic s);
      @(posedge i_mclk);
      #1 cv = {1'b1, s};
      @(posedge i_mclk);
      #1 cv = '0;
   endtask
   task automatic t_link;
      rc(4'h2, 8'ha0);
      h.wr(4'h2, 8'h20);
      le = 1'b1;
      pls(3'h1);
      h.wr(4'h4, 8'h01);
      chk({6'h0, sel}, 8'h00);
      rc(4'h2, 8'h90);
      h.wr(4'h2, 8'h10);
      le = 1'b0;
      pls(3'h1);
      rc(4'h2, 8'h80);
   endtask
   task automatic t_map;
      me = 1'b1;
      h.wr(4'hf, 8'h33);
      rc(4'h2, 8'h88);
      me = 1'b0;
      rc(4'h2, 8'h80);
      me = 1'b1;
      h.wr(4'hf, 8'h5a);
      rc(4'h2, 8'h80);
      h.wr(4'hf, 8'h00);
      h.wr(4'h2, 8'h08);
      rc(4'h2, 8'h80);
      me = 1'b0;
   endtask
   task automatic t_fault;
      pls(3'h4);
      h.wr(4'h2, 8'h04);
      rc(4'h2, 8'h84);
      h.key;
      rc(4'h2, 8'ha0);
      h.wr(4'h2, 8'h20);
   endtask
   task automatic t_sel;
      for (int k = 0; k < 4; k++) begin
         h.wr(4'h4, {6'h3f, k[1:0]});
         rc(4'h4, 8'(k));
      end
      h.key;
      chk({7'h0, srst}, 8'h01);
      @(posedge i_mclk);
      #1 chk({6'h0, sel}, 8'h00);
      h.wr(4'h2, 8'h20);
      h.wr(4'h5, 8'hff);
      chk(afe, 8'h7b);
   endtask
   task automatic t_conv;
      h.start;
      done_p(1'b1);
      rc(4'h2, 8'h83);
      chk({7'h0, new_data_indicator_n}, 8'h00);
      pls(3'h2);
      chk({7'h0, new_data_indicator_n}, 8'h01);
      h.wr(4'h6, 8'h00);
      chk({7'h0, restart}, 8'h01);
      h.wr(4'h3, 8'h01);
      done_p(1'b0);
      rc(4'h2, 8'h81);
      h.wr(4'h3, 8'h03);
      chk({7'h0, run}, 8'h00);
   endtask
   // Every trigger mode: start, stop, complete
   task automatic t_mode;
      for (int m = 0; m < 4; m++) begin
         tm = m[1:0];
         h.start;
         chk({7'h0, run}, 8'h01);
         h.wr(4'h3, 8'h01);
         done_p(1'b0);
         chk({7'h0, run}, {7'h0, m == 2});
         tm = 2'h0;
         h.wr(4'h3, 8'h01);
         done_p(1'b0);
      end
      tm = 2'h1;
      h.start;
      done_p(1'b0);
      chk({7'h0, run}, 8'h00);
      pls(3'h2);
      chk({7'h0, new_data_indicator_n}, 8'h00);
      h.start;
      chk({7'h0, new_data_indicator_n}, 8'h01);
      done_p(1'b0);
   endtask
   task automatic test_done;
      $display("errors=%0d checks=%0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Watchdog cuts a hang short
   initial begin
      #100000;
      num_errors++;
      test_done;
   end
   initial begin
      repeat (10) @(posedge i_mclk);
      #1 i_arst_n = 1'b1;
      t_link;
      t_map;
      t_fault;
      t_sel;
      t_conv;
      t_mode;
      test_done;
   end
endmodule
